// file: include/fcd_pkg.sv
// fcd_pkg: constants for the flash command sequencer (host side)
// assumes a parallel nor flash with separate chip, output and write enables
package fcd_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 200;
  // strobe timing in ns, counts derived at the clock rate
  localparam int T_SETUP_NS = 35;
  localparam int T_PULSE_NS = 35;
  localparam int T_READ_NS  = 70;
  localparam int T_HOLD_NS  = 20;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC  = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC  = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  // cycles for read data to settle through the synchroniser
  localparam int SYNC_CYC  = 3;
  localparam int CNT_W = 8;
  // command data values
  localparam logic [7:0] D_UNLOCK1 = 8'haa;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_IDENT   = 8'h90;
  localparam logic [7:0] D_PROGRAM = 8'ha0;
  localparam logic [7:0] D_ERASE   = 8'h80;
  localparam logic [7:0] D_CHIP    = 8'h10;
  localparam logic [7:0] D_SECTOR  = 8'h30;
  localparam logic [7:0] D_RESUME  = 8'h30;
  localparam logic [7:0] D_SUSPEND = 8'hb0;
  localparam logic [7:0] D_RESET   = 8'hf0;
  // unlock addresses on a10..a0 (word) or a10..a-1 (byte)
  localparam logic [11:0] A_WORD1 = 12'h555;
  localparam logic [11:0] A_WORD2 = 12'h2aa;
  localparam logic [11:0] A_BYTE1 = 12'haaa;
  localparam logic [11:0] A_BYTE2 = 12'h555;
  // identifier and protect-verify offsets
  localparam logic [11:0] A_ID_MFR   = 12'h000;
  localparam logic [11:0] A_ID_DEV   = 12'h001;
  localparam logic [11:0] A_PROT_WRD = 12'h002;
  localparam logic [11:0] A_PROT_BYT = 12'h004;
  localparam int SECT_LO = 12;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO  = 8'h00;
  // host operation codes
  typedef enum logic [3:0] {
    FCD_OP_READ    = 4'h0,
    FCD_OP_RESET   = 4'h1,
    FCD_OP_PROGRAM = 4'h2,
    FCD_OP_CHIP_ER = 4'h3,
    FCD_OP_SECT_ER = 4'h4,
    FCD_OP_SUSPEND = 4'h5,
    FCD_OP_RESUME  = 4'h6,
    FCD_OP_ID_MFR  = 4'h7,
    FCD_OP_ID_DEV  = 4'h8,
    FCD_OP_PROT    = 4'h9,
    FCD_OP_HV_MFR  = 4'ha,
    FCD_OP_HV_DEV  = 4'hb,
    FCD_OP_HV_PROT = 4'hc
  } fcd_op_t;
endpackage : fcd_pkg

// file: src/fcd_seq_rom.sv
// fcd_seq_rom: registered table of bus cycles for each host operation
// assumes the caller holds op stable while stepping idx
`timescale 1ns/1ps
`default_nettype none
module fcd_seq_rom (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire fcd_pkg::fcd_op_t op,
  input  wire logic [2:0]       idx,
  input  wire logic             byte_mode,
  output logic      [2:0]       len,
  output logic      [11:0]      cyc_addr,
  output logic      [7:0]       cyc_data,
  output logic                  use_user_addr,
  output logic                  use_user_data
);
  import fcd_pkg::*;
  logic [11:0] u1;
  logic [11:0] u2;
  logic [2:0]  len_next;
  logic [11:0] addr_next;
  logic [7:0]  data_next;
  logic        ua_next;
  logic        ud_next;
  logic [7:0]  d [0:5];
  logic [11:0] a [0:5];

  always_comb begin
    u1 = byte_mode ? A_BYTE1 : A_WORD1;
    u2 = byte_mode ? A_BYTE2 : A_WORD2;
    d[0] = D_UNLOCK1; a[0] = u1;
    d[1] = D_UNLOCK2; a[1] = u2;
    d[2] = D_ERASE;   a[2] = u1;
    d[3] = D_UNLOCK1; a[3] = u1;
    d[4] = D_UNLOCK2; a[4] = u2;
    d[5] = D_CHIP;    a[5] = u1;
    len_next = 3'd0;
    ua_next  = 1'b0;
    ud_next  = 1'b0;
    case (op)
      FCD_OP_RESET: begin
        d[0] = D_RESET;
        len_next = 3'd1;
      end
      FCD_OP_SUSPEND: begin
        d[0] = D_SUSPEND;
        len_next = 3'd1;
      end
      FCD_OP_RESUME: begin
        d[0] = D_RESUME;
        len_next = 3'd1;
      end
      FCD_OP_PROGRAM: begin
        d[2] = D_PROGRAM;
        len_next = 3'd4;
        ua_next = (idx == 3'd3);
        ud_next = (idx == 3'd3);
      end
      FCD_OP_ID_MFR, FCD_OP_ID_DEV, FCD_OP_PROT: begin
        d[2] = D_IDENT;
        len_next = 3'd3;
      end
      FCD_OP_CHIP_ER: begin
        len_next = 3'd6;
      end
      FCD_OP_SECT_ER: begin
        d[5] = D_SECTOR;
        len_next = 3'd6;
        ua_next = (idx == 3'd5);
      end
      default: len_next = 3'd0;
    endcase
    addr_next = (idx < 3'd6) ? a[idx] : 12'h000;
    data_next = (idx < 3'd6) ? d[idx] : 8'h00;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      len           <= 3'd0;
      cyc_addr      <= 12'h000;
      cyc_data      <= 8'h00;
      use_user_addr <= 1'b0;
      use_user_data <= 1'b0;
    end else begin
      len           <= len_next;
      cyc_addr      <= addr_next;
      cyc_data      <= data_next;
      use_user_addr <= ua_next;
      use_user_data <= ud_next;
    end
  end
endmodule : fcd_seq_rom
`default_nettype wire

// file: src/fcd_host.sv
// fcd_host: host controller that issues command sequences to a nor flash
// assumes a device on the flash pins obeying the command set below
// Function
// - high voltage on a9 selects identifier reads
// - in-system identify via four-cycle 90h sequence
// - sector address on top bits for protect check
// - program: aa, 55, a0, then location/value
// - chip erase: six unlock writes ending 10h
// - sector erase: sixth write 30h at sector
// - unlock addresses 555/2aa word, aaa/555 byte
`timescale 1ns/1ps
`default_nettype none
module fcd_host (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire fcd_pkg::fcd_op_t              req_op,
  input  wire logic [fcd_pkg::ADDR_W-1:0]    req_addr,
  input  wire logic [fcd_pkg::DATA_W-1:0]    req_data,
  input  wire logic                          byte_mode,
  output logic                               rsp_valid,
  output logic      [fcd_pkg::DATA_W-1:0]    rsp_data,
  output logic      [fcd_pkg::ADDR_W-1:0]    flash_addr,
  output logic                               flash_addr_lsb,
  output logic                               flash_ce_n,
  output logic                               flash_oe_n,
  output logic                               flash_we_n,
  output logic                               flash_byte_n,
  output logic                               id_high_voltage,
  output logic      [fcd_pkg::DATA_W-1:0]    flash_dq_out,
  output logic                               flash_dq_oe,
  input  wire logic [fcd_pkg::DATA_W-1:0]    flash_dq_in
);
  import fcd_pkg::*;

  typedef enum logic [2:0] {
    FCD_IDLE  = 3'b000,
    FCD_FETCH = 3'b001,
    FCD_WSET  = 3'b010,
    FCD_WPUL  = 3'b011,
    FCD_WHLD  = 3'b100,
    FCD_RSET  = 3'b101,
    FCD_RWAIT = 3'b110,
    FCD_DONE  = 3'b111
  } fcd_state_t;

  fcd_state_t             state_reg, state_next;
  fcd_op_t                op_reg, op_next;
  logic [ADDR_W-1:0]      addr_reg, addr_next;
  logic [DATA_W-1:0]      data_reg, data_next;
  logic [2:0]             idx_reg, idx_next;
  logic [CNT_W-1:0]       cnt_reg, cnt_next;
  logic                   bm_reg, bm_next;
  logic [DATA_W-1:0]      rsp_reg, rsp_next;
  logic [ADDR_W-1:0]      fa_reg, fa_next;
  logic                   fl_reg, fl_next;
  logic                   ce_reg, ce_next;
  logic                   oe_reg, oe_next;
  logic                   we_reg, we_next;
  logic                   hv_reg, hv_next;
  logic [DATA_W-1:0]      dq_reg, dq_next;
  logic                   dqe_reg, dqe_next;
  logic [DATA_W-1:0]      dq_s1, dq_s2, dq_s3;
  logic [2:0]             len;
  logic [11:0]            cyc_addr;
  logic [7:0]             cyc_data;
  logic                   use_ua;
  logic                   use_ud;
  logic                   is_read_op;
  logic [11:0]            rd_low;
  logic [ADDR_W:0]        rd_full;

  // rom fed next values so its registered output lines up with fetch
  fcd_seq_rom u_rom (
    .clock         (clock),
    .rst           (rst),
    .op            (op_next),
    .idx           (idx_next),
    .byte_mode     (bm_next),
    .len           (len),
    .cyc_addr      (cyc_addr),
    .cyc_data      (cyc_data),
    .use_user_addr (use_ua),
    .use_user_data (use_ud)
  );

  // pin input synchroniser, three stages
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  always_comb begin
    is_read_op = (op_reg == FCD_OP_READ) || (op_reg == FCD_OP_ID_MFR) || (op_reg == FCD_OP_ID_DEV)
                 || (op_reg == FCD_OP_PROT) || (op_reg == FCD_OP_HV_MFR) || (op_reg == FCD_OP_HV_DEV)
                 || (op_reg == FCD_OP_HV_PROT);
    // identifier and protect offsets, a6 and a1 low for id
    case (op_reg)
      FCD_OP_ID_MFR, FCD_OP_HV_MFR: rd_low = A_ID_MFR;
      FCD_OP_ID_DEV, FCD_OP_HV_DEV: rd_low = bm_reg ? {A_ID_DEV[10:0], 1'b0} : A_ID_DEV;
      FCD_OP_PROT, FCD_OP_HV_PROT:  rd_low = bm_reg ? A_PROT_BYT : A_PROT_WRD;
      default:                      rd_low = 12'h000;
    endcase
    rd_full = {addr_reg, 1'b0};
    if (op_reg != FCD_OP_READ) begin
      // sector bits from the request, rest zero
      rd_full = {addr_reg[ADDR_W-1:SECT_LO], {SECT_LO{1'b0}}, 1'b0};
      rd_full[11:0] = bm_reg ? rd_low : {rd_low[10:0], 1'b0};
    end else if (bm_reg) begin
      rd_full = {addr_reg, 1'b0} >> 1;
    end
  end

  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    data_next  = data_reg;
    idx_next   = idx_reg;
    cnt_next   = cnt_reg;
    bm_next    = bm_reg;
    rsp_next   = rsp_reg;
    fa_next    = fa_reg;
    fl_next    = fl_reg;
    ce_next    = ce_reg;
    oe_next    = oe_reg;
    we_next    = we_reg;
    hv_next    = hv_reg;
    dq_next    = dq_reg;
    dqe_next   = dqe_reg;
    case (state_reg)
      FCD_IDLE: begin
        if (req_valid) begin
          op_next    = req_op;
          addr_next  = req_addr;
          data_next  = req_data;
          bm_next    = byte_mode;
          idx_next   = 3'd0;
          state_next = FCD_FETCH;
        end
      end
      FCD_FETCH: begin
        // rom output valid now
        cnt_next = '0;
        if (idx_reg < len) begin
          // unlock address on a10..a0 or a10..a-1, upper bits zero
          fa_next = '0;
          fl_next = 1'b0;
          if (bm_reg) begin
            fa_next[10:0] = cyc_addr[11:1];
            fl_next       = cyc_addr[0];
          end else begin
            fa_next[10:0] = cyc_addr[10:0];
          end
          if (use_ua) begin
            fa_next = addr_reg;
          end
          dq_next    = use_ud ? data_reg : {8'h00, cyc_data};
          dqe_next   = 1'b1;
          ce_next    = 1'b0;
          state_next = FCD_WSET;
        end else if (is_read_op) begin
          {fa_next, fl_next} = rd_full;
          hv_next    = (op_reg == FCD_OP_HV_MFR) || (op_reg == FCD_OP_HV_DEV)
                       || (op_reg == FCD_OP_HV_PROT);
          ce_next    = 1'b0;
          oe_next    = 1'b0;
          state_next = FCD_RSET;
        end else begin
          state_next = FCD_DONE;
        end
      end
      FCD_WSET: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(SETUP_CYC)) begin
          we_next    = 1'b0; // address taken at this falling edge
          cnt_next   = '0;
          state_next = FCD_WPUL;
        end
      end
      FCD_WPUL: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(PULSE_CYC)) begin
          we_next    = 1'b1; // data taken at this rising edge
          cnt_next   = '0;
          state_next = FCD_WHLD;
        end
      end
      FCD_WHLD: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(HOLD_CYC)) begin
          ce_next    = 1'b1;
          dqe_next   = 1'b0;
          idx_next   = idx_reg + 3'd1;
          state_next = FCD_FETCH;
        end
      end
      FCD_RSET: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(READ_CYC)) begin
          cnt_next   = '0;
          state_next = FCD_RWAIT;
        end
      end
      FCD_RWAIT: begin
        // let data pass the synchroniser
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg >= CNT_W'(SYNC_CYC) && dq_s2 == dq_s3) begin
          rsp_next   = (op_reg == FCD_OP_READ) ? dq_s3 : {8'h00, dq_s3[7:0]};
          ce_next    = 1'b1;
          oe_next    = 1'b1;
          hv_next    = 1'b0;
          state_next = FCD_DONE;
        end
      end
      FCD_DONE: begin
        state_next = FCD_IDLE;
      end
      default: state_next = FCD_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= FCD_IDLE;
      op_reg    <= FCD_OP_READ;
      addr_reg  <= '0;
      data_reg  <= '0;
      idx_reg   <= 3'd0;
      cnt_reg   <= '0;
      bm_reg    <= 1'b0;
      rsp_reg   <= '0;
      fa_reg    <= '0;
      fl_reg    <= 1'b0;
      ce_reg    <= 1'b1;
      oe_reg    <= 1'b1;
      we_reg    <= 1'b1;
      hv_reg    <= 1'b0;
      dq_reg    <= '0;
      dqe_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      data_reg  <= data_next;
      idx_reg   <= idx_next;
      cnt_reg   <= cnt_next;
      bm_reg    <= bm_next;
      rsp_reg   <= rsp_next;
      fa_reg    <= fa_next;
      fl_reg    <= fl_next;
      ce_reg    <= ce_next;
      oe_reg    <= oe_next;
      we_reg    <= we_next;
      hv_reg    <= hv_next;
      dq_reg    <= dq_next;
      dqe_reg   <= dqe_next;
    end
  end

  assign req_ready       = (state_reg == FCD_IDLE);
  assign rsp_valid       = (state_reg == FCD_DONE);
  assign rsp_data        = rsp_reg;
  assign flash_addr      = fa_reg;
  assign flash_addr_lsb  = fl_reg;
  assign flash_ce_n      = ce_reg;
  assign flash_oe_n      = oe_reg;
  assign flash_we_n      = we_reg;
  assign flash_byte_n    = ~bm_reg;
  assign id_high_voltage = hv_reg;
  assign flash_dq_out    = dq_reg;
  assign flash_dq_oe     = dqe_reg;
endmodule : fcd_host
`default_nettype wire

// file: tb/fcd_host_chk.sv
// fcd_host_chk: flash pin cycle checks
// assumes bind to the fcd_host ports
`timescale 1ns/1ps
`default_nettype none
module fcd_host_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [19:0] flash_addr,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        id_high_voltage,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_idle: assert property (
    $fell(rst) |-> flash_ce_n && flash_oe_n && flash_we_n && !flash_dq_oe && req_ready)
    else $error("pins busy after reset");
  a_write_strobes: assert property (
    !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe && $stable(flash_addr) && $stable(flash_dq_out))
    else $error("write cycle strobes wrong");
  a_we_setup: assert property ($rose(flash_dq_oe) |-> flash_we_n [*8] ##1 !flash_we_n)
    else $error("write setup wrong");
  a_we_pulse: assert property ($fell(flash_we_n) |-> !flash_we_n [*8] ##1 flash_we_n)
    else $error("write pulse wrong");
  a_we_hold: assert property (
    $rose(flash_we_n) |-> (!flash_ce_n && flash_dq_oe) [*5] ##1 (flash_ce_n && !flash_dq_oe))
    else $error("write hold wrong");
  a_read_bus: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
    else $error("read strobes wrong");
  a_read_hold: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8] ##8 !flash_oe_n)
    else $error("read too short");
  a_hv_read: assert property (id_high_voltage |-> !flash_oe_n && !flash_addr[6])
    else $error("high voltage outside read");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && req_ready)
    else $error("response not single");
  a_take_busy: assert property (req_valid && req_ready |=> !req_ready)
    else $error("request not taken");
endmodule : fcd_host_chk
`default_nettype wire

// file: tb/fcd_flash_model.sv
// fcd_flash_model: behavioural nor flash on the host pins
// assumes host strobes; sector erase is timed, chip erase and program instant
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_model #(
  parameter logic [7:0]  MFR_CODE = 8'h5e,
  parameter logic [15:0] DEV_CODE = 16'h3a71,
  parameter int          ERS_NS   = 2500
) (
  input  wire logic [19:0] flash_addr,
  input  wire logic        flash_addr_lsb,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_byte_n,
  input  wire logic        id_high_voltage,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe,
  output logic      [15:0] flash_dq_in
);
  import fcd_pkg::*;
  logic [15:0] mem [int];
  logic [255:0] ers_sec = '0;
  logic [2:0] st = 3'h0;
  logic idm = 1'b0;
  logic susp = 1'b0;
  realtime ers_end = 0, rem = 0;
  logic [19:0] fa;
  logic [11:0] la = '0, u1 = A_WORD1, u2 = A_WORD2; // no false unlock on the reset strobe edge
  logic [7:0] d;
  logic [15:0] idv, rdat;
  wire wr = !flash_ce_n && !flash_we_n;
  function automatic logic [15:0] arr(logic [19:0] a);
    return mem.exists(a) ? mem[a] : ers_sec[a[19:12]] ? 16'hffff : a[15:0] ^ 16'h5a5a;
  endfunction : arr
  always @(posedge wr) begin // address on falling strobe
    fa = flash_addr;
    la = flash_byte_n ? {1'b0, flash_addr[10:0]} : {flash_addr[10:0], flash_addr_lsb};
    u1 = flash_byte_n ? A_WORD1 : A_BYTE1;
    u2 = flash_byte_n ? A_WORD2 : A_BYTE2;
  end
  always @(negedge wr) begin // data on rising strobe
    d = flash_dq_oe ? flash_dq_out[7:0] : ~flash_dq_out[7:0];
    if ($realtime < ers_end && !susp) begin // erase busy
      if (d == D_SUSPEND) begin
        susp = 1'b1;
        rem = ers_end - $realtime;
      end
    end else if (st == 3'h3) begin
      mem[fa] = arr(fa) & flash_dq_out;
      st = 3'h0;
    end else if (st == 3'h0 && susp && d == D_RESUME) begin
      susp = 1'b0;
      ers_end = $realtime + rem;
    end else begin
      if (d == D_RESET) idm = 1'b0;
      case (st) // wrong value aborts
        3'h0, 3'h4: st = (d == D_UNLOCK1 && la == u1) ? st + 3'h1 : 3'h0;
        3'h1, 3'h5: st = (d == D_UNLOCK2 && la == u2) ? st + 3'h1 : 3'h0;
        3'h2: begin
          idm = idm || (la == u1 && d == D_IDENT);
          st = la != u1 ? 3'h0 : d == D_PROGRAM ? 3'h3 : d == D_ERASE ? 3'h4 : 3'h0;
        end
        3'h6: begin
          if (d == D_CHIP && la == u1) begin
            mem.delete();
            ers_sec = '1;
          end
          if (d == D_SECTOR) begin
            ers_sec[fa[19:12]] = 1'b1;
            ers_end = $realtime + ERS_NS;
          end
          st = 3'h0;
        end
        default: st = 3'h0;
      endcase
    end
  end
  always_comb begin // identifier store
    case (flash_addr[1:0])
      2'h0: idv = {8'h00, MFR_CODE};
      2'h1: idv = flash_byte_n ? DEV_CODE : {8'h00, DEV_CODE[7:0]};
      2'h2: idv = {15'h0, flash_addr[12]};
      default: idv = 16'h0;
    endcase
  end
  always @(flash_addr, flash_oe_n, id_high_voltage, idm, idv) begin
    rdat = (id_high_voltage || idm) ? idv : arr(flash_addr);
  end
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rdat : ~rdat;
endmodule : fcd_flash_model
`default_nettype wire

// file: tb/fcd_host_tb.sv
// fcd_host_tb: random and corner operations against the flash model
// assumes fcd_host, fcd_flash_model and fcd_host_chk
`timescale 1ns/1ps
`default_nettype none
module fcd_host_tb;
  import fcd_pkg::*;
  localparam logic [7:0]  MFR = 8'h5e;    // arbitrary value
  localparam logic [15:0] DEV = 16'h3a71; // arbitrary value
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, byte_mode = 1'b0;
  fcd_op_t req_op = FCD_OP_READ;
  logic [19:0] req_addr = '0, flash_addr, a;
  logic [15:0] req_data = '0, rsp_data, flash_dq_out, flash_dq_in, d;
  logic req_ready, rsp_valid, flash_addr_lsb, flash_ce_n, flash_oe_n, flash_we_n;
  logic flash_byte_n, id_high_voltage, flash_dq_oe;
  int err_count = 0, cmp_count = 0, cyc = 0, seed = 32'h3d77;
  fcd_host dut (.clock, .rst, .req_valid, .req_ready, .req_op, .req_addr, .req_data, .byte_mode,
    .rsp_valid, .rsp_data, .flash_addr, .flash_addr_lsb, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_byte_n, .id_high_voltage, .flash_dq_out, .flash_dq_oe, .flash_dq_in);
  fcd_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .ERS_NS(2500)) fm (.flash_addr, .flash_addr_lsb,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_byte_n, .id_high_voltage, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in);
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task automatic op(fcd_op_t o, logic [19:0] ad, logic [15:0] dd, logic bm);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= ad;
    req_data <= dd;
    byte_mode <= bm;
    @(posedge clock);
    while (req_ready !== 1'b1) @(posedge clock);
    req_valid <= 1'b0;
    @(posedge clock);
    while (rsp_valid !== 1'b1) @(posedge clock);
  endtask : op
  task automatic rc(fcd_op_t o, logic [19:0] ad, logic bm, logic [15:0] e);
    op(o, ad, 16'h0, bm);
    chk(o.name(), e, rsp_data);
  endtask : rc
  function automatic logic [15:0] arr_exp(logic [19:0] ad);
    return ad[15:0] ^ 16'h5a5a;
  endfunction : arr_exp
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = 20'($random(seed));
      rc(FCD_OP_READ, a, 1'b0, arr_exp(a));
    end
    rc(FCD_OP_ID_MFR, 20'h0, 1'b0, {8'h00, MFR});
    rc(FCD_OP_ID_DEV, 20'h0, 1'b0, {8'h00, DEV[7:0]});
    op(FCD_OP_RESET, 20'h0, 16'h0, 1'b0);
    rc(FCD_OP_READ, 20'h3, 1'b0, arr_exp(20'h3));
    rc(FCD_OP_HV_MFR, 20'h0, 1'b0, {8'h00, MFR});
    rc(FCD_OP_HV_DEV, 20'h0, 1'b0, {8'h00, DEV[7:0]});
    rc(FCD_OP_HV_DEV, 20'h0, 1'b1, {8'h00, DEV[7:0]});
    for (int i = 0; i < 8; i++) begin
      a = 20'($random(seed));
      rc(i < 4 ? FCD_OP_PROT : FCD_OP_HV_PROT, a, i[0], {15'h0, a[12]});
    end
    op(FCD_OP_RESET, 20'h0, 16'h0, 1'b0);
    a = 20'($random(seed));
    d = 16'($random(seed));
    op(FCD_OP_SECT_ER, a, 16'h0, 1'b0);
    op(FCD_OP_PROGRAM, a, d, 1'b0);
    repeat (600) @(posedge clock);
    rc(FCD_OP_READ, a, 1'b0, 16'hffff);
    op(FCD_OP_PROGRAM, a, d, 1'b0);
    rc(FCD_OP_READ, a, 1'b0, d);
    op(FCD_OP_SECT_ER, a, 16'h0, 1'b0);
    op(FCD_OP_SUSPEND, a, 16'h0, 1'b0);
    chk("suspended", 16'h1, {15'h0, fm.susp});
    op(FCD_OP_RESUME, a, 16'h0, 1'b0);
    chk("resumed", 16'h0, {15'h0, fm.susp});
    repeat (600) @(posedge clock);
    op(FCD_OP_SUSPEND, a, 16'h0, 1'b0);
    chk("idle suspend", 16'h0, {15'h0, fm.susp});
    op(FCD_OP_CHIP_ER, 20'h0, 16'h0, 1'b1);
    rc(FCD_OP_READ, a ^ 20'h5, 1'b0, 16'hffff);
    wrap_up();
  end
endmodule : fcd_host_tb
bind fcd_host fcd_host_chk u_chk (.clock, .rst, .req_valid, .req_ready, .rsp_valid, .flash_addr,
  .flash_ce_n, .flash_oe_n, .flash_we_n, .id_high_voltage, .flash_dq_out, .flash_dq_oe);
`default_nettype wire
